// ### pkg/cfa_pkg.sv
package cfa_pkg;

  // register byte offsets, one aligned word each
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_OPERANDS = 8'h04;
  localparam logic [7:0] OFS_COMMAND = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0C;
  localparam logic [7:0] OFS_INDEX_FIRST = 8'h10;
  localparam logic [7:0] OFS_INDEX_SECOND = 8'h14;
  localparam logic [7:0] OFS_INSTR_LO = 8'h18;
  localparam logic [7:0] OFS_INSTR_HI = 8'h1C;
  localparam logic [7:0] OFS_DECODE_CTRL = 8'h20;
  localparam logic [7:0] OFS_EA = 8'h24;
  localparam logic [7:0] OFS_NEXT_PC = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;

  // flag_register bit positions
  localparam int FLG_C = 0;
  localparam int FLG_V = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_N = 3;
  localparam int FLG_I = 4;
  localparam int FLG_H = 5;
  localparam int FLG_X = 6;
  localparam int FLG_S = 7;
  localparam logic [7:0] FLAGS_RESET = 8'hD0;

  // command register fields
  localparam int CMD_IDX_SEL = 4;
  localparam logic [3:0] OP_ADD = 4'h0;
  localparam logic [3:0] OP_ADC = 4'h1;
  localparam logic [3:0] OP_ADD_ACC = 4'h2;
  localparam logic [3:0] OP_SUB = 4'h3;
  localparam logic [3:0] OP_CMP = 4'h4;
  localparam logic [3:0] OP_AND = 4'h5;
  localparam logic [3:0] OP_LOAD = 4'h6;
  localparam logic [3:0] OP_INC16 = 4'h7;
  localparam logic [3:0] OP_DEC16 = 4'h8;
  localparam logic [3:0] OP_DIV = 4'h9;
  localparam logic [3:0] OP_HALT = 4'hA;

  // decode control fields and addressing modes
  localparam int DCTL_WIDE = 3;
  localparam int DCTL_IDX_SEL = 4;
  localparam int DCTL_TAKEN = 5;
  localparam int DCTL_EXTRA = 6;
  localparam logic [2:0] MODE_IMM = 3'h0;
  localparam logic [2:0] MODE_DIR = 3'h1;
  localparam logic [2:0] MODE_EXT = 3'h2;
  localparam logic [2:0] MODE_IDX = 3'h3;
  localparam logic [2:0] MODE_INH = 3'h4;
  localparam logic [2:0] MODE_REL = 3'h5;

  localparam int STACK_CYCLES_DEFAULT = 9;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_STACK = 3'b010,
    SEQ_VECTOR = 3'b100
  } cfa_seq_type;

endpackage : cfa_pkg

// ### pkg/cfa_ea_if.sv
`timescale 1ns/100ps
interface cfa_ea_if;
  logic [31:0] instr_lo;
  logic [7:0] instr_hi;
  logic [15:0] pc;
  logic [15:0] idx;
  logic [2:0] mode;
  logic wide;
  logic extra;
  logic taken;
  logic [15:0] ea;
  logic [15:0] next_pc;
  logic [7:0] opcode;
  logic [1:0] page;
  logic [2:0] length;
  logic prefixed;

  modport core (output instr_lo, instr_hi, pc, idx, mode, wide, extra, taken,
                input ea, next_pc, opcode, page, length, prefixed);
  modport gen (input instr_lo, instr_hi, pc, idx, mode, wide, extra, taken,
               output ea, next_pc, opcode, page, length, prefixed);
endinterface : cfa_ea_if

// ### hdl/cfa_ea_gen.sv
`timescale 1ns/100ps
module cfa_ea_gen
  import cfa_pkg::*;
#(
  // prefix byte values are arbitrary
  parameter logic [7:0] PREFIX_PAGE1 = 8'hE1,
  parameter logic [7:0] PREFIX_PAGE2 = 8'hE2,
  parameter logic [7:0] PREFIX_PAGE3 = 8'hE3
)
(
  cfa_ea_if.gen ea
);
  wire [7:0] b0 = ea.instr_lo[7:0];
  wire [7:0] b1 = ea.instr_lo[15:8];
  wire [7:0] b2 = ea.instr_lo[23:16];
  wire [7:0] b3 = ea.instr_lo[31:24];
  wire is_p1 = (b0 == PREFIX_PAGE1);
  wire is_p2 = (b0 == PREFIX_PAGE2);
  wire is_p3 = (b0 == PREFIX_PAGE3);
  wire pfx = is_p1 | is_p2 | is_p3;
  wire [7:0] op1 = pfx ? b2 : b1;
  wire [7:0] op2 = pfx ? b3 : b2;
  wire [15:0] after_op = ea.pc + (pfx ? 16'h0002 : 16'h0001);
  logic [1:0] opnd_cnt;
  logic [15:0] ea_val;
  wire [2:0] len = 3'h1 + {2'h0, pfx} + {1'b0, opnd_cnt};
  wire [15:0] seq_pc = ea.pc + {13'h0000, len};
  wire [15:0] br_target = seq_pc + {{8{op1[7]}}, op1};

  assign ea.prefixed = pfx;
  assign ea.page = is_p1 ? 2'h1 : is_p2 ? 2'h2 : is_p3 ? 2'h3 : 2'h0;
  assign ea.opcode = pfx ? b1 : b0;
  assign ea.length = len;
  assign ea.ea = ea_val;
  assign ea.next_pc = (ea.mode == MODE_REL && ea.taken) ? br_target : seq_pc;

  always_comb
  begin
    opnd_cnt = 2'h0;
    ea_val = 16'h0000;
    case (ea.mode)
      MODE_IMM:
      begin
        opnd_cnt = ea.wide ? 2'h2 : 2'h1;
        ea_val = after_op;
      end
      MODE_DIR:
      begin
        opnd_cnt = ea.extra ? 2'h2 : 2'h1;
        ea_val = {8'h00, op1};
      end
      MODE_EXT:
      begin
        opnd_cnt = ea.extra ? 2'h3 : 2'h2;
        ea_val = {op1, op2};
      end
      MODE_IDX:
      begin
        opnd_cnt = ea.extra ? 2'h2 : 2'h1;
        ea_val = ea.idx + {8'h00, op1};
      end
      MODE_REL:
      begin
        opnd_cnt = 2'h1;
        ea_val = br_target;
      end
      default:
      begin
        opnd_cnt = 2'h0;
        ea_val = 16'h0000;
      end
    endcase
  end
endmodule : cfa_ea_gen

// ### hdl/cfa_core.sv
// Operation
// - carry set on carry, borrow, divide error
// - overflow set on overflow, else cleared
// - zero flag follows zero result
// - compare updates flags, discards result
// - sixteen-bit index inc/dec touch only zero
// - negative flag copies result top bit; divide leaves it unchanged
// - maskable mask blocks, requests stay pending
// - reset sets maskable mask; software clears
// - maskable entry sets mask before vector
// - half carry from bit three additions
// - pin mask blocks pin; reset sets
// - pin entry sets both masks before vector
// - software can never set pin mask
// - pin mask cleared only by flag load
// - halt is no-op while disabled
// - words stored high byte first, unaligned
// - prefix byte selects one of four pages
// - instructions one to five bytes long
// - immediate operand follows opcode
// - direct mode high byte is zero
// - extended address from two bytes
// - indexed adds unsigned offset to index
// - taken branch adds signed offset
//
// Added by the designer: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/100ps
module cfa_core
  import cfa_pkg::*;
#(
  parameter int STACK_CYCLES = STACK_CYCLES_DEFAULT
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic maskable_request,
  input wire logic nonmaskable_request_pin_n,
  output logic [7:0] flags,
  output logic stacking,
  output logic vector_fetch,
  output logic vector_nonmask,
  output logic low_power
);
  localparam int CW = $clog2(STACK_CYCLES + 1);

  // bus data-phase capture
  logic dp_wr_r;
  logic [7:0] dp_addr_r;
  logic [31:0] hrdata_r;
  logic hreadyout_r;

  // programmer-visible state
  logic [7:0] flags_r;
  logic [7:0] flags_nxt;
  logic [15:0] operands_r;
  logic [7:0] result_r;
  logic [15:0] index_first_r;
  logic [15:0] index_second_r;
  logic [31:0] instr_lo_r;
  logic [31:0] instr_hi_r;
  logic [7:0] dctl_r;
  logic low_power_r;

  // interrupt entry sequencer
  cfa_seq_type seq_r;
  cfa_seq_type seq_nxt;
  logic [CW-1:0] cnt_r;
  logic kind_r;

  cfa_ea_if ea_bus ();

  cfa_ea_gen u_ea_gen (
    .ea (ea_bus)
  );

  // address phase decode
  wire addr_ok = (haddr[31:8] == 24'h000000);
  wire take = hsel && htrans[1] && hready;
  wire [7:0] ofs = haddr[7:0];

  // data phase write strobes
  wire wr_flags = dp_wr_r && (dp_addr_r == OFS_FLAGS);
  wire wr_opnd = dp_wr_r && (dp_addr_r == OFS_OPERANDS);
  wire wr_cmd = dp_wr_r && (dp_addr_r == OFS_COMMAND);
  wire wr_ix = dp_wr_r && (dp_addr_r == OFS_INDEX_FIRST);
  wire wr_iy = dp_wr_r && (dp_addr_r == OFS_INDEX_SECOND);
  wire wr_ilo = dp_wr_r && (dp_addr_r == OFS_INSTR_LO);
  wire wr_ihi = dp_wr_r && (dp_addr_r == OFS_INSTR_HI);
  wire wr_dctl = dp_wr_r && (dp_addr_r == OFS_DECODE_CTRL);

  // command decode
  wire [3:0] op = hwdata[3:0];
  wire op_sel_y = hwdata[CMD_IDX_SEL];
  wire [7:0] opa = operands_r[7:0];
  wire [7:0] opb = operands_r[15:8];
  wire cin = (op == OP_ADC) ? flags_r[FLG_C] : 1'b0;

  // arithmetic unit
  wire [8:0] sum9 = {1'b0, opa} + {1'b0, opb} + {8'h00, cin};
  wire [4:0] half5 = {1'b0, opa[3:0]} + {1'b0, opb[3:0]} + {4'h0, cin};
  wire [8:0] diff9 = {1'b0, opa} - {1'b0, opb};
  wire [7:0] and8 = opa & opb;
  wire div_err = (opb == 8'h00);
  wire [7:0] quot = div_err ? 8'hFF : (opa / opb);
  wire add_v = (opa[7] == opb[7]) && (sum9[7] != opa[7]);
  wire sub_v = (opa[7] != opb[7]) && (diff9[7] != opa[7]);
  wire [15:0] idx_cur = op_sel_y ? index_second_r : index_first_r;
  wire [15:0] idx_new = (op == OP_DEC16) ? (idx_cur - 16'h0001) : (idx_cur + 16'h0001);
  wire is_add = (op == OP_ADD) || (op == OP_ADC) || (op == OP_ADD_ACC);
  wire is_sub = (op == OP_SUB) || (op == OP_CMP);
  wire is_idx = (op == OP_INC16) || (op == OP_DEC16);

  logic [7:0] alu_res;
  logic [7:0] alu_flags;
  logic alu_res_we;

  always_comb
  begin
    alu_res = 8'h00;
    alu_res_we = 1'b0;
    alu_flags = flags_r;
    if (is_add)
    begin
      alu_res = sum9[7:0];
      alu_res_we = 1'b1;
      alu_flags[FLG_C] = sum9[8];
      alu_flags[FLG_V] = add_v;
      alu_flags[FLG_H] = half5[4];
      alu_flags[FLG_Z] = (sum9[7:0] == 8'h00);
      alu_flags[FLG_N] = sum9[7];
    end
    else if (is_sub)
    begin
      alu_res = diff9[7:0];
      alu_res_we = (op == OP_SUB);
      alu_flags[FLG_C] = diff9[8];
      alu_flags[FLG_V] = sub_v;
      alu_flags[FLG_Z] = (diff9[7:0] == 8'h00);
      alu_flags[FLG_N] = diff9[7];
    end
    else if ((op == OP_AND) || (op == OP_LOAD))
    begin
      alu_res = (op == OP_AND) ? and8 : opa;
      alu_res_we = 1'b1;
      alu_flags[FLG_V] = 1'b0;
      alu_flags[FLG_Z] = (alu_res == 8'h00);
      alu_flags[FLG_N] = alu_res[7];
    end
    else if (op == OP_DIV)
    begin
      alu_res = quot;
      alu_res_we = 1'b1;
      alu_flags[FLG_C] = div_err;
      alu_flags[FLG_V] = 1'b0;
      alu_flags[FLG_Z] = (quot == 8'h00);
    end
    else if (is_idx)
    begin
      alu_flags[FLG_Z] = (idx_new == 16'h0000);
    end
  end

  // interrupt recognition: pin request first, masks gate both
  wire nmi_req = ~nonmaskable_request_pin_n;
  wire nmi_go = nmi_req && !flags_r[FLG_X];
  wire irq_go = maskable_request && !flags_r[FLG_I];
  wire seq_start = (seq_r == SEQ_IDLE) && (nmi_go || irq_go);
  wire stack_done = (seq_r == SEQ_STACK) && (cnt_r == {CW{1'b0}});
  wire set_i = stack_done;
  wire set_x = stack_done && kind_r;
  wire halt_req = wr_cmd && (op == OP_HALT);

  always_comb
  begin
    case (seq_r)
      SEQ_IDLE:
        seq_nxt = seq_start ? SEQ_STACK : SEQ_IDLE;
      SEQ_STACK:
        seq_nxt = stack_done ? SEQ_VECTOR : SEQ_STACK;
      SEQ_VECTOR:
        seq_nxt = SEQ_IDLE;
      default:
        seq_nxt = SEQ_IDLE;
    endcase
  end

  // software loads may clear the pin mask but never set it; hardware sets win
  always_comb
  begin
    flags_nxt = flags_r;
    if (wr_flags)
    begin
      flags_nxt = hwdata[7:0];
      flags_nxt[FLG_X] = flags_r[FLG_X] & hwdata[FLG_X];
    end
    else if (wr_cmd)
    begin
      flags_nxt = alu_flags;
    end
    if (set_i)
    begin
      flags_nxt[FLG_I] = 1'b1;
    end
    if (set_x)
    begin
      flags_nxt[FLG_X] = 1'b1;
    end
  end

  // read mux sampled in the address phase, so data stands for the data phase
  wire [31:0] status_word = {27'h0000000, seq_r != SEQ_IDLE, low_power_r,
                             nmi_req, maskable_request, 1'b0};
  wire [31:0] ea_word = {2'h0, ea_bus.prefixed, ea_bus.length, ea_bus.page,
                         ea_bus.opcode, ea_bus.ea};
  wire [31:0] rd_mux =
    !addr_ok ? 32'h00000000 :
    (ofs == OFS_FLAGS) ? {24'h000000, flags_r} :
    (ofs == OFS_OPERANDS) ? {16'h0000, operands_r} :
    (ofs == OFS_RESULT) ? {24'h000000, result_r} :
    (ofs == OFS_INDEX_FIRST) ? {16'h0000, index_first_r} :
    (ofs == OFS_INDEX_SECOND) ? {16'h0000, index_second_r} :
    (ofs == OFS_INSTR_LO) ? instr_lo_r :
    (ofs == OFS_INSTR_HI) ? instr_hi_r :
    (ofs == OFS_DECODE_CTRL) ? {24'h000000, dctl_r} :
    (ofs == OFS_EA) ? ea_word :
    (ofs == OFS_NEXT_PC) ? {16'h0000, ea_bus.next_pc} :
    (ofs == OFS_STATUS) ? status_word :
    32'h00000000;

  // decoder inputs: instruction bytes in fetch order, pc in the high half
  assign ea_bus.instr_lo = instr_lo_r;
  assign ea_bus.instr_hi = instr_hi_r[7:0];
  assign ea_bus.pc = instr_hi_r[31:16];
  assign ea_bus.mode = dctl_r[2:0];
  assign ea_bus.wide = dctl_r[DCTL_WIDE];
  assign ea_bus.extra = dctl_r[DCTL_EXTRA];
  assign ea_bus.taken = dctl_r[DCTL_TAKEN];
  assign ea_bus.idx = dctl_r[DCTL_IDX_SEL] ? index_second_r : index_first_r;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      dp_wr_r <= 1'b0;
      dp_addr_r <= 8'h00;
      hrdata_r <= 32'h00000000;
      hreadyout_r <= 1'b1;
    end
    else
    begin
      dp_wr_r <= take && hwrite && addr_ok;
      dp_addr_r <= ofs;
      if (take && !hwrite)
      begin
        hrdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      flags_r <= FLAGS_RESET;
    end
    else
    begin
      flags_r <= flags_nxt;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      operands_r <= 16'h0000;
      result_r <= 8'h00;
      instr_lo_r <= 32'h00000000;
      instr_hi_r <= 32'h00000000;
      dctl_r <= 8'h00;
    end
    else
    begin
      if (wr_opnd)
      begin
        operands_r <= hwdata[15:0];
      end
      if (wr_cmd && alu_res_we)
      begin
        result_r <= alu_res;
      end
      if (wr_ilo)
      begin
        instr_lo_r <= hwdata;
      end
      if (wr_ihi)
      begin
        instr_hi_r <= hwdata;
      end
      if (wr_dctl)
      begin
        dctl_r <= hwdata[7:0];
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      index_first_r <= 16'h0000;
      index_second_r <= 16'h0000;
    end
    else
    begin
      if (wr_ix)
      begin
        index_first_r <= hwdata[15:0];
      end
      else if (wr_cmd && is_idx && !op_sel_y)
      begin
        index_first_r <= idx_new;
      end
      if (wr_iy)
      begin
        index_second_r <= hwdata[15:0];
      end
      else if (wr_cmd && is_idx && op_sel_y)
      begin
        index_second_r <= idx_new;
      end
    end
  end

  // halt is dropped while disabled; any recognised interrupt wakes
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      low_power_r <= 1'b0;
    end
    else if (seq_start)
    begin
      low_power_r <= 1'b0;
    end
    else if (halt_req && !flags_r[FLG_S])
    begin
      low_power_r <= 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      seq_r <= SEQ_IDLE;
      cnt_r <= {CW{1'b0}};
      kind_r <= 1'b0;
    end
    else
    begin
      seq_r <= seq_nxt;
      if (seq_start)
      begin
        cnt_r <= CW'(STACK_CYCLES - 1);
        kind_r <= nmi_go;
      end
      else if ((seq_r == SEQ_STACK) && !stack_done)
      begin
        cnt_r <= cnt_r - {{(CW-1){1'b0}}, 1'b1};
      end
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0 & hreadyout_r;
  assign flags = flags_r;
  assign stacking = seq_r[1];
  assign vector_fetch = seq_r[2];
  assign vector_nonmask = kind_r;
  assign low_power = low_power_r;

endmodule : cfa_core

// ### tb/cfa_core_assertions.sv
`timescale 1ns/100ps
module cfa_core_assertions
  import cfa_pkg::*;
#(
  parameter int STACK_CYCLES = STACK_CYCLES_DEFAULT
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic maskable_request,
  input wire logic nonmaskable_request_pin_n,
  input wire logic [7:0] flags,
  input wire logic stacking,
  input wire logic vector_fetch,
  input wire logic vector_nonmask,
  input wire logic low_power
);
  logic [7:0] stack_cnt_r;
  logic flag_wr;
  assign flag_wr = hsel && htrans[1] && hready && hwrite && (haddr == {24'h000000, OFS_FLAGS});
  // counts stacking cycles; cleared whenever the phase is not running
  always_ff @(posedge clock)
  begin
    if (rst || !stacking)
      stack_cnt_r <= 8'h00;
    else
      stack_cnt_r <= stack_cnt_r + 8'h01;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_reset_flags: assert property ($fell(rst) |-> flags == FLAGS_RESET)
    else $error("flags not at reset value after reset");
  a_stack_len: assert property (vector_fetch |-> stack_cnt_r == STACK_CYCLES)
    else $error("stacking phase length wrong");
  a_vector_after_stack: assert property ($fell(stacking) |-> vector_fetch)
    else $error("vector fetch does not follow stacking");
  a_vector_masks: assert property (vector_fetch |-> flags[FLG_I] && (flags[FLG_X] || !vector_nonmask))
    else $error("masks not set at vector fetch");
  a_entry_cause: assert property ($rose(stacking) |->
    $past((!nonmaskable_request_pin_n && !flags[FLG_X]) || (maskable_request && !flags[FLG_I])))
    else $error("entry while masked or without request");
  a_pin_mask_hw: assert property ($rose(flags[FLG_X]) |-> vector_fetch)
    else $error("pin mask set outside acknowledge");
  a_mask_sw_clear: assert property (($fell(flags[FLG_X]) || $fell(flags[FLG_I])) |-> $past(flag_wr, 2))
    else $error("mask cleared without flag write");
  a_halt_gate: assert property ($rose(low_power) |-> $past(!flags[FLG_S]))
    else $error("halt entered while disabled");
endmodule : cfa_core_assertions

// ### tb/cfa_irq_src.sv
`timescale 1ns/100ps
module cfa_irq_src
(
  input wire logic clock,
  input wire logic rst,
  input wire logic fire_mask,
  input wire logic fire_pin,
  input wire logic vector_fetch,
  input wire logic vector_nonmask,
  output logic maskable_request,
  output logic nonmaskable_request_pin_n
);
  logic pin_req_r;
  // requests are levels held until acknowledged, so masking only delays them
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      maskable_request <= 1'b0;
      pin_req_r <= 1'b0;
    end
    else
    begin
      if (fire_mask)
        maskable_request <= 1'b1;
      else if (vector_fetch && !vector_nonmask)
        maskable_request <= 1'b0;
      if (fire_pin)
        pin_req_r <= 1'b1;
      else if (vector_fetch && vector_nonmask)
        pin_req_r <= 1'b0;
    end
  end
  assign nonmaskable_request_pin_n = !pin_req_r;
endmodule : cfa_irq_src

// ### tb/cpu_flags_and_address_modes_tb.sv
`timescale 1ns/100ps
module cpu_flags_and_address_modes_tb
  import cfa_pkg::*;
;
  localparam int STACK_CYCLES = 2;
  // {op, a, b, flags before, flags after, result}
  localparam logic [47:0] ALU_T [9] = '{48'h00_08_08_00_20_10, 48'h00_80_80_00_07_00, 48'h01_0F_00_01_20_10,
    48'h02_7F_01_00_2A_80, 48'h03_00_01_00_09_FF, 48'h04_05_05_00_04_FF, 48'h05_F0_80_01_09_80,
    48'h06_00_00_02_04_00, 48'h09_10_00_00_01_FF};
  // {instr bytes, pc, decode ctrl, read offset, mask, expected}
  localparam logic [127:0] DEC_T [10] = '{128'h00000086_FFFE_08_24_1C00FFFF_0C00FFFF,
    128'h000086E2_FFFE_00_24_03FFFFFF_02860000, 128'h00003496_1000_01_24_0000FFFF_00000034,
    128'h003412B6_1000_02_24_1C00FFFF_0C001234, 128'h000020A6_1000_03_24_0000FFFF_00000010,
    128'h0000F020_0010_25_28_0000FFFF_00000002, 128'h0000F020_0010_05_28_0000FFFF_00000012,
    128'h000008E1_2000_04_24_3FFFFFFF_29080000, 128'h0020A6E2_1000_53_24_1C00FFFF_10000120,
    128'h3412B6E3_1000_42_24_1FFFFFFF_17B61234};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h00000000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h00000000;
  logic fire_mask = 1'b0;
  logic fire_pin = 1'b0;
  logic hready;
  logic [31:0] hrdata;
  logic hresp;
  logic maskable_request;
  logic nonmaskable_request_pin_n;
  logic [7:0] flags;
  logic stacking;
  logic vector_fetch;
  logic vector_nonmask;
  logic low_power;
  logic [31:0] d;
  int mismatches = 0;
  int comparisons = 0;

  always #2.5 clock = ~clock;

  cfa_core #(.STACK_CYCLES(STACK_CYCLES)) dut_u (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .maskable_request(maskable_request),
    .nonmaskable_request_pin_n(nonmaskable_request_pin_n), .flags(flags), .stacking(stacking),
    .vector_fetch(vector_fetch), .vector_nonmask(vector_nonmask), .low_power(low_power));

  cfa_irq_src irq_u (.clock(clock), .rst(rst), .fire_mask(fire_mask), .fire_pin(fire_pin),
    .vector_fetch(vector_fetch), .vector_nonmask(vector_nonmask), .maskable_request(maskable_request),
    .nonmaskable_request_pin_n(nonmaskable_request_pin_n));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge clock);
    while (hready !== 1'b1)
      @(posedge clock);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clock);
    while (hready !== 1'b1)
      @(posedge clock);
    rd = hrdata;
    check(32'(hresp), 32'h0);
  endtask : bus

  task wr(input logic [7:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(1'b1, {24'h0, a}, v, x);
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] v);
    bus(1'b0, {24'h0, a}, 32'h0, v);
  endtask : rd

  task wait_vec();
    int n;
    n = 0;
    while (vector_fetch !== 1'b1 && n < 50)
    begin
      @(posedge clock);
      n++;
    end
    check(32'(vector_fetch), 32'h1);
  endtask : wait_vec

  task t_reset();
    check(32'(flags), 32'(FLAGS_RESET));
    rd(OFS_FLAGS, d);
    check(d, 32'h000000D0);
    bus(1'b0, 32'h00000100, 32'h0, d);
    check(d, 32'h0);
  endtask : t_reset

  task t_alu();
    for (int i = 0; i < 9; i++)
    begin
      wr(OFS_FLAGS, {24'h0, ALU_T[i][23:16]});
      wr(OFS_OPERANDS, {16'h0, ALU_T[i][31:24], ALU_T[i][39:32]});
      wr(OFS_COMMAND, {24'h0, ALU_T[i][47:40]});
      @(posedge clock);
      check(32'(flags), {24'h0, ALU_T[i][15:8]});
      rd(OFS_RESULT, d);
      check(d, {24'h0, ALU_T[i][7:0]});
    end
  endtask : t_alu

  task t_index();
    wr(OFS_INDEX_FIRST, 32'h0000FFFF);
    wr(OFS_FLAGS, 32'h0B);
    wr(OFS_COMMAND, 32'h07);
    @(posedge clock);
    check(32'(flags), 32'h0F);
    rd(OFS_INDEX_FIRST, d);
    check(d, 32'h0);
    wr(OFS_INDEX_SECOND, 32'h2);
    wr(OFS_COMMAND, 32'h18);
    @(posedge clock);
    check(32'(flags), 32'h0B);
    rd(OFS_INDEX_SECOND, d);
    check(d, 32'h1);
  endtask : t_index

  task t_halt();
    wr(OFS_FLAGS, 32'h80);
    wr(OFS_COMMAND, {28'h0, OP_HALT});
    @(posedge clock);
    check(32'(low_power), 32'h0);
    wr(OFS_FLAGS, 32'h00);
    wr(OFS_COMMAND, {28'h0, OP_HALT});
    @(posedge clock);
    check(32'(low_power), 32'h1);
  endtask : t_halt

  task t_masks();
    wr(OFS_FLAGS, 32'hFF);
    @(posedge clock);
    check(32'(flags), 32'hBF);
    wr(OFS_FLAGS, 32'h10);
    fire_mask <= 1'b1;
    @(posedge clock);
    fire_mask <= 1'b0;
    repeat (6) @(posedge clock);
    check(32'(stacking), 32'h0);
    rd(OFS_STATUS, d);
    check(d & 32'h2, 32'h2);
    wr(OFS_FLAGS, 32'h00);
    wait_vec();
    check(32'({vector_nonmask, low_power, flags}), 32'h010);
    fire_pin <= 1'b1;
    @(posedge clock);
    fire_pin <= 1'b0;
    wait_vec();
    check(32'({vector_nonmask, flags}), 32'h150);
    repeat (2) @(posedge clock);
    wr(OFS_FLAGS, 32'h00);
    @(posedge clock);
    check(32'(flags), 32'h00);
  endtask : t_masks

  // a second reset in mid-run must bring back every mask and drop the halt state
  task t_rerst();
    wr(OFS_COMMAND, {28'h0, OP_HALT});
    @(posedge clock);
    check(32'(low_power), 32'h1);
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    check(32'({low_power, flags}), 32'h0D0);
  endtask : t_rerst

  task t_decode();
    wr(OFS_INDEX_FIRST, 32'h0000FFF0);
    wr(OFS_INDEX_SECOND, 32'h00000100);
    for (int i = 0; i < 10; i++)
    begin
      wr(OFS_INSTR_LO, DEC_T[i][127:96]);
      wr(OFS_INSTR_HI, {DEC_T[i][95:80], 16'h0});
      wr(OFS_DECODE_CTRL, {24'h0, DEC_T[i][79:72]});
      rd(DEC_T[i][71:64], d);
      check(d & DEC_T[i][63:32], DEC_T[i][31:0]);
    end
  endtask : t_decode

  task conclude();
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_reset();
    t_alu();
    t_index();
    t_halt();
    t_masks();
    t_rerst();
    t_decode();
    conclude();
  end

  // far above the few hundred cycles the scenarios need
  initial
  begin
    repeat (20000) @(posedge clock);
    mismatches++;
    conclude();
  end
endmodule : cpu_flags_and_address_modes_tb

bind cfa_core cfa_core_assertions #(.STACK_CYCLES(STACK_CYCLES)) chk_u (.clock(clock), .rst(rst), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .maskable_request(maskable_request),
  .nonmaskable_request_pin_n(nonmaskable_request_pin_n), .flags(flags), .stacking(stacking),
  .vector_fetch(vector_fetch), .vector_nonmask(vector_nonmask), .low_power(low_power));
